// >>> verilog/acim_pkg.sv
// acim_pkg: register map, field positions and carrier types of the aux block
package acim_pkg;
   // register addresses
   localparam logic [7:0] ADDR_MAP2      = 8'h3b;
   localparam logic [7:0] ADDR_AUX_ADC_CONTROL   = 8'h3c;
   localparam logic [7:0] ADDR_TEMPERATURE_CONTROL  = 8'h3d;
   localparam logic [7:0] ADDR_THR_HI    = 8'h3e;
   localparam logic [7:0] ADDR_THR_LO    = 8'h3f;
   localparam logic [7:0] ADDR_INTHR_HI  = 8'h40;
   localparam logic [7:0] ADDR_INTHR_LO  = 8'h41;
   localparam logic [7:0] ADDR_TIMER     = 8'h42;
   // reset values
   localparam logic [7:0] RST_MAP2       = 8'h00;
   localparam logic [7:0] RST_AUX_ADC_CONTROL    = 8'hc0;
   localparam logic [7:0] RST_ZERO       = 8'h00;
   // writable bit masks (reserved bits read zero)
   localparam logic [7:0] WMASK_MAP2     = 8'hdf;
   localparam logic [7:0] WMASK_CTL      = 8'hcf;
   localparam logic [7:0] WMASK_TCTL     = 8'h0f;
   localparam logic [7:0] WMASK_THR_HI   = 8'h7f;
   localparam logic [7:0] WMASK_THR_LO   = 8'hfc;
   localparam logic [7:0] WMASK_ALL      = 8'hff;
   // map bit positions
   localparam int B_FUSE   = 7;
   localparam int B_UREG   = 6;
   localparam int B_KALV   = 4;
   localparam int B_AACT   = 3;
   localparam int B_AINACT = 2;
   localparam int B_DTAP   = 1;
   localparam int B_STAP   = 0;
   // control bit positions
   localparam int B_INACT_EN = 3;
   localparam int B_ACT_EN   = 1;
   localparam int B_CH_EN    = 0;
   localparam int B_FMT_HI   = 7;
   localparam int B_FMT_LO   = 6;
   // fifo word formats
   typedef enum logic [1:0] {
      ACIM_FMT_RSVD = 2'b00,
      ACIM_FMT_8    = 2'b01,
      ACIM_FMT_12   = 2'b10,
      ACIM_FMT_14ID = 2'b11
   } acim_fmt_t;
   // register write request
   typedef struct packed {
      logic       wr;
      logic [7:0] addr;
      logic [7:0] data;
   } acim_wreq_t;
   // sources of the second irq pin
   typedef struct packed {
      logic fuse_err;
      logic ureg_err;
      logic keepalive;
      logic double_tap;
      logic single_tap;
   } acim_events_t;
   // aux channel sample
   typedef struct packed {
      logic              valid;
      logic signed [13:0] data;
   } acim_sample_t;
endpackage

// >>> verilog/acim_regmem.sv
// acim_regmem: small byte register memory with masked writes, registered read
`timescale 1ns/1ps
module acim_regmem
   import acim_pkg::*;
#(
   parameter int N = 8
) (
   input  wire logic                 i_clk,
   input  wire logic                 i_rst,
   input  wire logic                 i_we,
   input  wire logic [2:0]           i_widx,
   input  wire logic [7:0]           i_wdata,
   input  wire logic [2:0]           i_ridx,
   output logic      [7:0]           o_rdata,
   output logic      [N-1:0][7:0]    o_regs
);
   // per-register reset value and write mask
   // reset values
   function automatic logic [7:0] rst_of(input int k);
      return (k == 1) ? RST_AUX_ADC_CONTROL : RST_ZERO;
   endfunction
   function automatic logic [7:0] mask_of(input int k);
      case (k)
         0: return WMASK_MAP2;
         1: return WMASK_CTL;
         2: return WMASK_TCTL;
         3, 5: return WMASK_THR_HI;
         4, 6: return WMASK_THR_LO;
         default: return WMASK_ALL;
      endcase
   endfunction

   // storage, reserved bits forced to zero
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         for (int k = 0; k < N; k++) o_regs[k] <= rst_of(k);
      end else if (i_we) begin
         o_regs[i_widx] <= i_wdata & mask_of(int'(i_widx));
      end
   end

   // registered read port
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         o_rdata <= RST_ZERO;
      end else begin
         o_rdata <= o_regs[i_ridx];
      end
   end
endmodule

// >>> verilog/acim_detect.sv
// acim_detect: absolute-value threshold with consecutive-sample counter
`timescale 1ns/1ps
module acim_detect
   import acim_pkg::*;
#(
   parameter int CW = 4
) (
   input  wire logic               i_clk,
   input  wire logic               i_rst,
   input  wire logic               i_en,
   input  wire logic               i_above,   // 1: count samples over thr
   input  acim_pkg::acim_sample_t  i_smp,
   input  wire logic [12:0]        i_thr,
   input  wire logic [CW-1:0]      i_count,
   output logic                    o_event
);
   logic [13:0]   mag;
   logic          hit;
   logic [CW-1:0] run_q;

   // magnitude of the signed sample, -8192 wraps harmlessly to the pattern read as 8192
   // abs compare
   always_comb begin
      mag = i_smp.data[13] ? 14'(-i_smp.data) : 14'(i_smp.data);
      hit = i_above ? (mag > {1'b0, i_thr}) : (mag < {1'b0, i_thr});
   end

   // consecutive-sample run; event once run passes the programmed count
   // activity count
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         run_q   <= '0;
         o_event <= 1'b0;
      end else if (!i_en) begin
         run_q   <= '0;
         o_event <= 1'b0;
      end else if (i_smp.valid) begin
         if (!hit) begin
            run_q   <= '0;
            o_event <= 1'b0;
         end else if (run_q >= i_count) begin
            o_event <= 1'b1;
         end else begin
            run_q   <= run_q + 1'b1;
            o_event <= (run_q + 1'b1) > i_count;
         end
      end
   end
endmodule

// >>> verilog/acim_top.sv
// acim_top: aux channel control and second irq pin upper map
`timescale 1ns/1ps
module acim_top
   import acim_pkg::*;
(
   input  wire logic                 I_CORE_CLK,
   input  wire logic                 I_SYS_RST,
   input  acim_pkg::acim_wreq_t      I_WREQ,
   input  wire logic [7:0]           I_RADDR,
   input  acim_pkg::acim_events_t    I_EVENTS,
   input  acim_pkg::acim_sample_t    I_AUX_SMP,
   input  wire logic                 I_SAMPLE_TICK,
   output logic      [7:0]           O_RDATA,
   output logic                      O_SECOND_IRQ_PIN,
   output acim_pkg::acim_fmt_t       O_FIFO_WORD_FORMAT,
   output logic                      O_EXT_ADC_EN,
   output logic                      O_TEMP_CONV_STB,
   output logic                      O_AUX_ACT_EVT,
   output logic                      O_AUX_INACT_EVT
);
   import acim_pkg::*;

   // -------------------------------------------------
   // register file
   // -------------------------------------------------
   logic [7:0][7:0] regs;
   logic            in_map_w;
   logic            in_map_r;
   logic [7:0]      mem_rdata;
   logic            rd_hit_q;

   // function: address inside the aux window
   function automatic logic in_window(input logic [7:0] a);
      return (a >= ADDR_MAP2) && (a <= ADDR_TIMER);
   endfunction

   assign in_map_w = in_window(I_WREQ.addr);
   assign in_map_r = in_window(I_RADDR);

   acim_regmem #(.N(8)) u_mem (
      .i_clk   (I_CORE_CLK),
      .i_rst   (I_SYS_RST),
      .i_we    (I_WREQ.wr && in_map_w),
      .i_widx  (3'(I_WREQ.addr - ADDR_MAP2)),
      .i_wdata (I_WREQ.data),
      .i_ridx  (3'(I_RADDR - ADDR_MAP2)),
      .o_rdata (mem_rdata),
      .o_regs  (regs)
   );

   logic [7:0] map2;
   logic [7:0] aux_adc_control;
   logic [7:0] temperature_control;
   logic [12:0] act_thr;
   logic [12:0] inact_thr;
   logic [7:0] timer;
   assign map2     = regs[0];
   assign aux_adc_control  = regs[1];
   assign temperature_control = regs[2];
   assign act_thr   = {regs[3][6:0], regs[4][7:2]};
   assign inact_thr = {regs[5][6:0], regs[6][7:2]};
   assign timer     = regs[7];

   // unmapped reads return zero; one cycle read latency
   always_ff @(posedge I_CORE_CLK or posedge I_SYS_RST) begin
      if (I_SYS_RST) begin
         rd_hit_q <= 1'b0;
      end else begin
         rd_hit_q <= in_map_r;
      end
   end
   assign O_RDATA = rd_hit_q ? mem_rdata : RST_ZERO;

   // -------------------------------------------------
   // channel control decode
   // -------------------------------------------------
   logic temp_en;
   logic ext_en;
   logic act_en;
   logic inact_en;
   assign temp_en = temperature_control[B_CH_EN];
   assign ext_en  = aux_adc_control[B_CH_EN] && !temp_en;
   assign act_en   = temp_en ? temperature_control[B_ACT_EN] :
                     (ext_en && aux_adc_control[B_ACT_EN]);
   assign inact_en = temp_en ? temperature_control[B_INACT_EN] :
                     (ext_en && aux_adc_control[B_INACT_EN]);

   // fifo format and channel outputs
   // format select
   always_ff @(posedge I_CORE_CLK or posedge I_SYS_RST) begin
      if (I_SYS_RST) begin
         O_FIFO_WORD_FORMAT <= ACIM_FMT_14ID;
         O_EXT_ADC_EN       <= 1'b0;
      end else begin
         O_FIFO_WORD_FORMAT <= (aux_adc_control[B_FMT_HI:B_FMT_LO] == 2'b00) ?
                               ACIM_FMT_14ID :
                               acim_fmt_t'(aux_adc_control[B_FMT_HI:B_FMT_LO]);
         O_EXT_ADC_EN       <= ext_en;
      end
   end

   always_ff @(posedge I_CORE_CLK or posedge I_SYS_RST) begin
      if (I_SYS_RST) begin
         O_TEMP_CONV_STB <= 1'b0;
      end else begin
         O_TEMP_CONV_STB <= I_SAMPLE_TICK && temp_en;
      end
   end

   // -------------------------------------------------
   // activity / inactivity detectors
   // -------------------------------------------------
   logic act_evt;
   logic inact_evt;

   acim_detect #(.CW(4)) u_act (
      .i_clk   (I_CORE_CLK),
      .i_rst   (I_SYS_RST),
      .i_en    (act_en),
      .i_above (1'b1),
      .i_smp   (I_AUX_SMP),
      .i_thr   (act_thr),
      .i_count (timer[3:0]),
      .o_event (act_evt)
   );

   acim_detect #(.CW(4)) u_inact (
      .i_clk   (I_CORE_CLK),
      .i_rst   (I_SYS_RST),
      .i_en    (inact_en),
      .i_above (1'b0),
      .i_smp   (I_AUX_SMP),
      .i_thr   (inact_thr),
      .i_count (timer[7:4]),
      .o_event (inact_evt)
   );

   always_ff @(posedge I_CORE_CLK or posedge I_SYS_RST) begin
      if (I_SYS_RST) begin
         O_AUX_ACT_EVT   <= 1'b0;
         O_AUX_INACT_EVT <= 1'b0;
      end else begin
         O_AUX_ACT_EVT   <= act_evt;
         O_AUX_INACT_EVT <= inact_evt;
      end
   end

   // -------------------------------------------------
   // second irq pin
   // -------------------------------------------------
   logic irq_d;
   // keep-alive on bit 4 is routed to this pin by choice; open for review
   // mapping gates
   assign irq_d = (map2[B_FUSE]   && I_EVENTS.fuse_err)   ||
                  (map2[B_UREG]   && I_EVENTS.ureg_err)   ||
                  (map2[B_KALV]   && I_EVENTS.keepalive)  ||
                  (map2[B_AACT]   && act_evt)             ||
                  (map2[B_AINACT] && inact_evt)           ||
                  (map2[B_DTAP]   && I_EVENTS.double_tap) ||
                  (map2[B_STAP]   && I_EVENTS.single_tap);

   always_ff @(posedge I_CORE_CLK or posedge I_SYS_RST) begin
      if (I_SYS_RST) begin
         O_SECOND_IRQ_PIN <= 1'b0;
      end else begin
         O_SECOND_IRQ_PIN <= irq_d;
      end
   end

   // -------------------------------------------------
   // assertions
   // -------------------------------------------------
   default clocking cb @(posedge I_CORE_CLK); endclocking
   default disable iff (I_SYS_RST);

   sequence s_fuse_mapped;
      map2[B_FUSE] && I_EVENTS.fuse_err;
   endsequence

   a_fuse_route_on: assert property (s_fuse_mapped |=> O_SECOND_IRQ_PIN)
      else $error("fuse error mapped but irq low");
   a_ureg_route_on: assert property (
      map2[B_UREG] && I_EVENTS.ureg_err |=> O_SECOND_IRQ_PIN)
      else $error("user reg error mapped but irq low");
   a_kalv_route_on: assert property (
      map2[B_KALV] && I_EVENTS.keepalive |=> O_SECOND_IRQ_PIN)
      else $error("keepalive mapped but irq low");
   a_act_route_on: assert property (
      map2[B_AACT] && act_evt |=> O_SECOND_IRQ_PIN)
      else $error("aux activity mapped but irq low");
   a_inact_route_on: assert property (
      map2[B_AINACT] && inact_evt |=> O_SECOND_IRQ_PIN)
      else $error("aux inactivity mapped but irq low");
   a_tap_route_on: assert property (
      (map2[B_DTAP] && I_EVENTS.double_tap) ||
      (map2[B_STAP] && I_EVENTS.single_tap) |=> O_SECOND_IRQ_PIN)
      else $error("tap mapped but irq low");
   a_irq_no_cause: assert property (
      map2 == RST_MAP2 |=> !O_SECOND_IRQ_PIN)
      else $error("irq high with empty map");
   a_temp_blocks_adc: assert property (
      temperature_control[B_CH_EN] |=> !O_EXT_ADC_EN)
      else $error("ext adc enabled while temperature on");
   a_fmt_follows: assert property (
      aux_adc_control[B_FMT_HI:B_FMT_LO] != 2'b00 |=>
      O_FIFO_WORD_FORMAT == $past(aux_adc_control[B_FMT_HI:B_FMT_LO]))
      else $error("fifo format mismatch");
   a_fmt_rsvd: assert property (
      aux_adc_control[B_FMT_HI:B_FMT_LO] == 2'b00 |=>
      O_FIFO_WORD_FORMAT == ACIM_FMT_14ID)
      else $error("reserved format not full");
   a_temp_conv: assert property (
      I_SAMPLE_TICK && temp_en |=> O_TEMP_CONV_STB)
      else $error("no temperature conversion");
   a_act_off: assert property (
      !act_en |=> !act_evt)
      else $error("activity event while disabled");
   a_inact_off: assert property (
      !inact_en |=> !inact_evt)
      else $error("inactivity event while disabled");
   a_map_rsvd: assert property (
      (map2 & ~WMASK_MAP2) == RST_ZERO)
      else $error("reserved map bit set");
   a_thr_rsvd: assert property (
      (regs[3] & ~WMASK_THR_HI) == RST_ZERO)
      else $error("reserved threshold bit set");

   // the fuse error never raises the pin while its map bit is clear and no other mapped source is active
   sequence s_other_idle;
      !(map2[B_UREG] && I_EVENTS.ureg_err) &&
      !(map2[B_KALV] && I_EVENTS.keepalive) &&
      !(map2[B_AACT] && act_evt) &&
      !(map2[B_AINACT] && inact_evt) &&
      !(map2[B_DTAP] && I_EVENTS.double_tap) &&
      !(map2[B_STAP] && I_EVENTS.single_tap);
   endsequence

   a_fuse_route_off: assert property (
      !map2[B_FUSE] ##0 s_other_idle |=> !O_SECOND_IRQ_PIN)
      else $error("fuse error unmapped but irq high");

   // channel enables follow the selected channel
   a_adc_en_on: assert property (
      aux_adc_control[B_CH_EN] && !temperature_control[B_CH_EN] |=> O_EXT_ADC_EN)
      else $error("ext adc not enabled");
   a_ext_act_en: assert property (
      !temp_en |-> act_en == (aux_adc_control[B_CH_EN] && aux_adc_control[B_ACT_EN]))
      else $error("ext activity enable wrong");
   a_ext_inact_en: assert property (
      !temp_en |-> inact_en == (aux_adc_control[B_CH_EN] && aux_adc_control[B_INACT_EN]))
      else $error("ext inactivity enable wrong");
   a_thermal_activity_enable: assert property (
      temp_en |-> act_en == temperature_control[B_ACT_EN])
      else $error("temperature activity enable wrong");
   a_thermal_inactivity_enable: assert property (
      temp_en |-> inact_en == temperature_control[B_INACT_EN])
      else $error("temperature inactivity enable wrong");
   a_temp_conv_off: assert property (
      !(I_SAMPLE_TICK && temp_en) |=> !O_TEMP_CONV_STB)
      else $error("temperature strobe without tick");

   // detector events reach the output pins one cycle later
   a_act_evt_out: assert property (
      act_evt |=> O_AUX_ACT_EVT)
      else $error("activity event not passed out");
   a_inact_evt_out: assert property (
      inact_evt |=> O_AUX_INACT_EVT)
      else $error("inactivity event not passed out");

   // an event only starts on a cycle after a valid sample
   a_act_needs_smp: assert property (
      $rose(act_evt) |-> $past(I_AUX_SMP.valid))
      else $error("activity event without sample");
   a_inact_needs_smp: assert property (
      $rose(inact_evt) |-> $past(I_AUX_SMP.valid))
      else $error("inactivity event without sample");
endmodule

// >>> dv/acim_host.sv
// acim_host: host processor model reaching the aux register bank
`timescale 1ns/1ps
module acim_host (
   input  wire logic            i_clk,
   output acim_pkg::acim_wreq_t o_wreq,
   output logic      [7:0]      o_raddr,
   input  wire logic [7:0]      i_rdata
);
   import acim_pkg::*;
   // ----------------------------------------
   // bus cycles
   // ----------------------------------------
   initial begin
      o_wreq  = '{wr: 1'b0, addr: 8'h00, data: 8'h00};
      o_raddr = 8'h00;
   end
   // one write strobe; released lines change so stale values never match
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge i_clk);
      #1;
      o_wreq = '{wr: 1'b1, addr: a, data: d};
      @(posedge i_clk);
      #1;
      o_wreq = '{wr: 1'b0, addr: ~a, data: ~d};
   endtask
   // read data arrives one edge after the address
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge i_clk);
      #1;
      o_raddr = a;
      @(posedge i_clk);
      #1;
      d = i_rdata;
   endtask
endmodule

// >>> dv/tb_top.sv
// tb_top: self-checking bench of the aux control and irq map block
`timescale 1ns/1ps
module tb_top;
   import acim_pkg::*;
   logic         clk;
   logic         rst;
   logic         tick;
   acim_wreq_t   wreq;
   logic [7:0]   raddr;
   logic [7:0]   rdata;
   acim_events_t ev;
   acim_sample_t smp;
   logic         irq;
   acim_fmt_t    fmt;
   logic         adc_en;
   logic         stb;
   logic         act;
   logic         inact;
   int           failures;
   int           cmp_count;
   // ----------------------------------------
   // design and host
   // ----------------------------------------
   acim_top i_dut (
      .I_CORE_CLK        (clk),
      .I_SYS_RST         (rst),
      .I_WREQ            (wreq),
      .I_RADDR           (raddr),
      .I_EVENTS          (ev),
      .I_AUX_SMP         (smp),
      .I_SAMPLE_TICK     (tick),
      .O_RDATA           (rdata),
      .O_SECOND_IRQ_PIN  (irq),
      .O_FIFO_WORD_FORMAT(fmt),
      .O_EXT_ADC_EN      (adc_en),
      .O_TEMP_CONV_STB   (stb),
      .O_AUX_ACT_EVT     (act),
      .O_AUX_INACT_EVT   (inact)
   );
   acim_host i_host (
      .i_clk  (clk),
      .o_wreq (wreq),
      .o_raddr(raddr),
      .i_rdata(rdata)
   );
   // ----------------------------------------
   // helpers
   // ----------------------------------------
   task automatic chk(string n, logic [7:0] e, logic [7:0] g);
      cmp_count++;
      if (g !== e) begin
         failures++;
         $display("mismatch %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic cyc(int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   // one valid sample; data changes afterwards
   task automatic send(logic signed [13:0] v);
      @(posedge clk);
      #1;
      smp = '{valid: 1'b1, data: v};
      @(posedge clk);
      #1;
      smp = '{valid: 1'b0, data: ~v};
   endtask
   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   task automatic t_regs();
      logic [7:0] d;
      logic [7:0] m [8] = '{8'hdf, 8'hcf, 8'h0f, 8'h7f,
                            8'hfc, 8'h7f, 8'hfc, 8'hff};
      for (int a = 0; a < 8; a++) begin
         i_host.rd(8'h3b + 8'(a), d);
         chk("reset reg", (a == 1) ? RST_AUX_ADC_CONTROL : RST_ZERO, d);
         i_host.wr(8'h3b + 8'(a), 8'hff);
         i_host.rd(8'h3b + 8'(a), d);
         chk("masked reg", m[a], d); // reserved bits
         i_host.wr(8'h3b + 8'(a), 8'h00);
      end
      i_host.wr(8'h3a, 8'hff);
      i_host.rd(8'h3a, d);
      chk("unmapped", 8'h00, d);
   endtask
   task automatic t_irq();
      logic [7:0] mb [5] = '{8'h80, 8'h40, 8'h10, 8'h02, 8'h01};
      for (int i = 0; i < 5; i++) begin
         i_host.wr(ADDR_MAP2, ~mb[i] & WMASK_MAP2);
         ev = acim_events_t'(5'b10000 >> i);
         cyc(2);
         chk("irq unmapped", 8'h00, 8'(irq));
         i_host.wr(ADDR_MAP2, mb[i]);
         cyc(1);
         chk("irq mapped", 8'h01, 8'(irq));
         ev = '0;
         cyc(1);
         chk("irq cleared", 8'h00, 8'(irq));
      end
   endtask
   task automatic t_ctl();
      for (int c = 0; c < 4; c++) begin
         i_host.wr(ADDR_AUX_ADC_CONTROL, {2'(c), 6'h01});
         cyc(1);
         chk("format", (c == 0) ? 8'h03 : 8'(c), 8'(fmt));
         chk("adc enable", 8'h01, 8'(adc_en));
      end
      i_host.wr(ADDR_TEMPERATURE_CONTROL, 8'h01);
      cyc(1);
      chk("adc blocked", 8'h00, 8'(adc_en));
      for (int k = 0; k < 2; k++) begin
         tick = 1'b1;
         cyc(1);
         tick = 1'b0;
         chk("temp strobe", 8'(1 - k), 8'(stb));
         cyc(1);
         chk("strobe end", 8'h00, 8'(stb));
         i_host.wr(ADDR_TEMPERATURE_CONTROL, 8'h00);
      end
   endtask
   task automatic t_act();
      i_host.wr(ADDR_THR_LO, 8'h14);
      i_host.wr(ADDR_TIMER, 8'h12);
      i_host.wr(ADDR_AUX_ADC_CONTROL, 8'hc3);
      i_host.wr(ADDR_MAP2, 8'h08);
      send(-14'sd6);
      send(14'sd6);
      cyc(3);
      chk("act early", 8'h00, 8'(act));
      send(-14'sd6);
      cyc(3);
      chk("act event", 8'h01, 8'(act));
      chk("act irq", 8'h01, 8'(irq));
      send(-14'sd5);
      cyc(3);
      chk("act at thr", 8'h00, 8'(act));
   endtask
   task automatic t_inact();
      i_host.wr(ADDR_INTHR_LO, 8'h14);
      i_host.wr(ADDR_TEMPERATURE_CONTROL, 8'h09);
      i_host.wr(ADDR_MAP2, 8'h04);
      send(14'sd4);
      cyc(3);
      chk("inact early", 8'h00, 8'(inact));
      send(-14'sd4);
      cyc(3);
      chk("inact event", 8'h01, 8'(inact));
      chk("inact irq", 8'h01, 8'(irq));
      i_host.wr(ADDR_TEMPERATURE_CONTROL, 8'h01);
      cyc(3);
      chk("inact off", 8'h00, 8'(inact));
   endtask
   // mid-run reset puts registers and outputs back to their reset state
   task automatic t_reset();
      logic [7:0] d;
      ev = '{fuse_err: 1'b1, default: 1'b0};
      i_host.wr(ADDR_MAP2, 8'hff);
      i_host.wr(ADDR_AUX_ADC_CONTROL, 8'h41);
      cyc(1);
      chk("pre rst format", 8'h01, 8'(fmt));
      chk("pre rst irq", 8'h01, 8'(irq));
      rst = 1'b1;
      cyc(2);
      chk("rst irq", 8'h00, 8'(irq));
      chk("rst format", 8'h03, 8'(fmt));
      rst = 1'b0;
      i_host.rd(ADDR_MAP2, d);
      chk("rst map", RST_MAP2, d);
      i_host.rd(ADDR_AUX_ADC_CONTROL, d);
      chk("rst aux_adc_control", RST_AUX_ADC_CONTROL, d);
      chk("rst irq held", 8'h00, 8'(irq));
      ev = '0;
   endtask
   // ----------------------------------------
   // clock, reset, sequence and verdict
   // ----------------------------------------
   task automatic conclude();
      $display("comparisons %0d failures %0d", cmp_count, failures);
      if (failures == 0 && cmp_count > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   // watchdog well beyond the roughly two hundred cycles the tests need
   initial begin
      #200000;
      failures++;
      conclude();
   end
   initial begin
      rst = 1'b1;
      tick = 1'b0;
      ev = '0;
      smp = '0;
      failures = 0;
      cmp_count = 0;
      cyc(12);
      rst = 1'b0;
      t_regs();
      t_irq();
      t_ctl();
      t_act();
      t_inact();
      t_reset();
      conclude();
   end
endmodule
